// ### hw/wrap_pkg.sv
// shared constants, types and helpers for the core bus wrapper
package wrap_pkg;
    // clock rate and microsecond stall timing
    localparam int CLK_FREQ_MHZ = 20;
    localparam int USEC_NS      = 1000;
    localparam int CYC_PER_US   = (USEC_NS * CLK_FREQ_MHZ + 999) / 1000;

    // stall register: address, field width and reset value
    localparam logic [31:0] STALL_ADDR = 32'h1000_0000;
    localparam int          STALL_W    = 5;
    localparam logic [4:0]  STALL_RST  = 5'h00;

    // bus encodings
    localparam logic [1:0] HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE    = 3'h0;
    localparam logic [2:0] HSIZE_HALF    = 3'h1;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic [3:0] BE_WORD       = 4'hf;

    // default address regions
    localparam logic [31:0] MEM_ALIAS_BASE = 32'h2000_0000;
    localparam logic [31:0] MEM_ALIAS_SIZE = 32'h0008_0000;
    localparam logic [31:0] BB_ALIAS_BASE  = 32'h2200_0000;
    localparam logic [31:0] BB_ALIAS_SPAN  = 32'h0100_0000;
    localparam logic [31:0] BB_TARGET_BASE = 32'h2000_0000;

    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_WAIT = 2'b01,
        P_DONE = 2'b10
    } port_st_t;

    typedef enum logic [2:0] {
        E_IDLE  = 3'b000,
        E_MEM   = 3'b001,
        E_SADR  = 3'b010,
        E_SDAT  = 3'b011,
        E_STALL = 3'b100,
        E_DONE  = 3'b101
    } eng_st_t;

    // byte lanes of a transfer from its size and low address bits
    function automatic logic [3:0] byte_en(input logic [2:0] size, input logic [1:0] lo);
        logic [3:0] m;
        m = (size == HSIZE_BYTE) ? 4'h1 : (size == HSIZE_HALF) ? 4'h3 : BE_WORD;
        return m << lo;
    endfunction
endpackage

// ### hw/usec_tick.sv
// microsecond enable divider, restartable
`timescale 1ns/1ps
module usec_tick #(
    parameter int CYC = wrap_pkg::CYC_PER_US
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // restart and tick
    input  wire logic clear,
    output logic      tick
);
    import wrap_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
    } tick_state_t;

    tick_state_t q, d;

    // a clear restarts the period so a stall gets whole microseconds
    always_comb begin
        d = q;
        if (clear || tick) begin
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + 16'h1;
        end
        if (rst) begin
            d = '0;
        end
    end

    assign tick = !clear && (q.cnt == 16'(CYC - 1));

    always_ff @(posedge clk) begin
        q <= d;
    end
endmodule

// ### hw/ahb_req_port.sv
// bus-lite slave front end that turns each transfer into a held request
`timescale 1ns/1ps
module ahb_req_port (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // bus-lite slave side
    input  wire logic [1:0]  htrans,
    input  wire logic [31:0] haddr,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // request side
    output logic             req,
    output logic [31:0]      addr,
    output logic             we,
    output logic [2:0]       size,
    output logic [3:0]       be,
    input  wire logic        ack,
    input  wire logic [31:0] ack_rdata
);
    import wrap_pkg::*;

    typedef struct packed {
        port_st_t    st;
        logic [31:0] addr;
        logic        we;
        logic [2:0]  size;
        logic [31:0] rdata;
    } port_state_t;

    port_state_t q, d;

    // address phase taken whenever ready is high; data phase waits on ack
    always_comb begin
        d = q;
        unique case (q.st)
            P_WAIT: begin
                if (ack) begin
                    d.st    = P_DONE;
                    d.rdata = ack_rdata;
                end
            end
            P_IDLE, P_DONE: begin
                d.st = P_IDLE;
                if (htrans[1]) begin
                    d.st   = P_WAIT;
                    d.addr = haddr;
                    d.we   = hwrite;
                    d.size = hsize;
                end
            end
            default: d.st = P_IDLE;
        endcase
        if (rst) begin
            d = '0;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    // write data stays live on the master's data bus while waiting
    assign hreadyout = (q.st != P_WAIT);
    assign hrdata    = q.rdata;
    assign hresp     = 1'b0;
    assign req       = (q.st == P_WAIT);
    assign addr      = q.addr;
    assign we        = q.we;
    assign size      = q.size;
    assign be        = byte_en(q.size, q.addr[1:0]);
endmodule

// ### hw/core_bus_debug_stall_wrapper.sv
// core wrapper: memory ports, system bus, stall register, debug and trace
`timescale 1ns/1ps
// Operation
// - fetch port becomes prioritised SRAM-style memory requests
// - data port becomes top-priority SRAM-style requests
// - core system port bridged to arbitrated system bus
// - arbitration serves extra master and bit-band accesses
// - memories also answer at system-bus alias addresses
// - bit-band write does whole-word read-modify-write
// - debug pins carry two-wire or four-wire links
// - debug pins shareable with boundary scan
// - debug off until firmware enable is written
// - hit halts core or raises monitor exception
// - software trace writes never stall the core
// - patch unit may remap fetches onto RAM
// - watchpoint trace stream enters the trace path
// - one trace output carries all three streams
// - instruction trace stream forwarded to trace output
// - stall write n holds core n+1 microseconds
// - stall read returns last value, no delay
// - trace output runs on undivided input clock
module core_bus_debug_stall_wrapper #(
    parameter logic [31:0] MEM_BASE  = wrap_pkg::MEM_ALIAS_BASE,
    parameter logic [31:0] MEM_SIZE  = wrap_pkg::MEM_ALIAS_SIZE,
    parameter logic [31:0] BB_ALIAS  = wrap_pkg::BB_ALIAS_BASE,
    parameter logic [31:0] BB_SPAN   = wrap_pkg::BB_ALIAS_SPAN,
    parameter logic [31:0] BB_TARGET = wrap_pkg::BB_TARGET_BASE,
    parameter int          CYC_US    = wrap_pkg::CYC_PER_US
) (
    // clock and system reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    // instruction fetch port
    input  wire logic [1:0]  IF_HTRANS,
    input  wire logic [31:0] IF_HADDR,
    output logic             IF_HREADYOUT,
    output logic [31:0]      IF_HRDATA,
    output logic             IF_HRESP,
    // data access port
    input  wire logic [1:0]  DA_HTRANS,
    input  wire logic [31:0] DA_HADDR,
    input  wire logic        DA_HWRITE,
    input  wire logic [2:0]  DA_HSIZE,
    input  wire logic [31:0] DA_HWDATA,
    output logic             DA_HREADYOUT,
    output logic [31:0]      DA_HRDATA,
    output logic             DA_HRESP,
    // core system port
    input  wire logic [1:0]  SC_HTRANS,
    input  wire logic [31:0] SC_HADDR,
    input  wire logic        SC_HWRITE,
    input  wire logic [2:0]  SC_HSIZE,
    input  wire logic [31:0] SC_HWDATA,
    output logic             SC_HREADYOUT,
    output logic [31:0]      SC_HRDATA,
    output logic             SC_HRESP,
    // extra system bus master
    input  wire logic        XM_HBUSREQ,
    output logic             XM_HGRANT,
    input  wire logic [1:0]  XM_HTRANS,
    input  wire logic [31:0] XM_HADDR,
    input  wire logic        XM_HWRITE,
    input  wire logic [2:0]  XM_HSIZE,
    input  wire logic [31:0] XM_HWDATA,
    output logic             XM_HREADY,
    output logic [31:0]      XM_HRDATA,
    output logic             XM_HRESP,
    // on-chip memory bus
    output logic             MEM_CS,
    output logic             MEM_WE,
    output logic [3:0]       MEM_BE,
    output logic [31:0]      MEM_ADDR,
    output logic [31:0]      MEM_WDATA,
    input  wire logic [31:0] MEM_RDATA,
    // system bus master side
    output logic [31:0]      SB_HADDR,
    output logic [1:0]       SB_HTRANS,
    output logic             SB_HWRITE,
    output logic [2:0]       SB_HSIZE,
    output logic [31:0]      SB_HWDATA,
    input  wire logic        SB_HREADY,
    input  wire logic [31:0] SB_HRDATA,
    // fetch patching
    input  wire logic        PATCH_REMAP,
    input  wire logic [31:0] PATCH_ADDR,
    // debug pins
    input  wire logic        DEBUG_ENABLE,
    input  wire logic        BSCAN_SEL,
    input  wire logic        PIN_TCK,
    input  wire logic        PIN_TMS_I,
    output logic             PIN_TMS_O,
    output logic             PIN_TMS_OE,
    input  wire logic        PIN_TDI,
    output logic             PIN_TDO_O,
    output logic             PIN_TDO_OE,
    // core debug port side
    output logic             DP_CLK,
    output logic             DP_TMS,
    output logic             DP_TDI,
    input  wire logic        DP_SWDO,
    input  wire logic        DP_SWDOEN,
    input  wire logic        DP_TDO,
    input  wire logic        DP_MODE_SWD,
    // boundary scan side
    output logic             BS_TCK,
    output logic             BS_TMS,
    output logic             BS_TDI,
    input  wire logic        BS_TDO,
    // breakpoint handling
    input  wire logic        BP_HIT,
    input  wire logic        HALT_ON_HIT,
    input  wire logic        DBG_RESUME,
    output logic             CORE_HALT,
    output logic             MON_EXC,
    // trace streams and output
    input  wire logic        ITM_VALID,
    input  wire logic [7:0]  ITM_DATA,
    input  wire logic        DWT_VALID,
    input  wire logic [7:0]  DWT_DATA,
    input  wire logic        ETM_VALID,
    input  wire logic [7:0]  ETM_DATA,
    output logic             TRACE_VALID,
    output logic [7:0]       TRACE_DATA,
    output logic             TRACE_LOST
);
    import wrap_pkg::*;

    typedef struct packed {
        eng_st_t     st;
        logic        own_x;
        logic        last_x;
        logic        bb;
        logic        wb;
        logic        we;
        logic [4:0]  bit_no;
        logic [31:0] addr;
        logic [2:0]  size;
        logic [3:0]  be;
        logic [31:0] wdata;
        logic [31:0] res;
        logic [4:0]  stall;
        logic [4:0]  cnt;
        logic [2:0]  mack;
        logic        dbg_en;
        logic        halt;
        logic        mon;
        logic        tdo_o;
        logic        tdo_oe;
        logic        swd_o;
        logic        swd_oe;
        logic [7:0]  trc_data;
        logic        trc_valid;
        logic        trc_lost;
    } wrap_state_t;

    wrap_state_t q, d;

    logic        d_req, i_req, s_req, x_req;
    logic [31:0] d_addr, i_addr, s_addr, x_addr;
    logic        d_we, s_we, x_we;
    logic [2:0]  s_size, x_size;
    logic [3:0]  d_be, s_be, x_be;
    logic        g_d, g_i, g_a, a_req, tick, take_x, fin, sub_we, dp_live;
    logic [31:0] a, off, fin_data, i_mem;

    // pick the memory region or the outside bus for one word access
    function automatic eng_st_t route(input logic [31:0] ad);
        return (ad - MEM_BASE < MEM_SIZE) ? E_MEM : E_SADR;
    endfunction

    // front ends: fetch and data to memory, core and extra master to the engine
    ahb_req_port u_if (
        .clk(CLK_SYS), .rst(RST), .htrans(IF_HTRANS), .haddr(IF_HADDR),
        .hwrite(1'b0), .hsize(HSIZE_WORD), .hreadyout(IF_HREADYOUT),
        .hrdata(IF_HRDATA), .hresp(IF_HRESP), .req(i_req), .addr(i_addr),
        .we(), .size(), .be(), .ack(q.mack[1]), .ack_rdata(MEM_RDATA)
    );
    ahb_req_port u_da (
        .clk(CLK_SYS), .rst(RST), .htrans(DA_HTRANS), .haddr(DA_HADDR),
        .hwrite(DA_HWRITE), .hsize(DA_HSIZE), .hreadyout(DA_HREADYOUT),
        .hrdata(DA_HRDATA), .hresp(DA_HRESP), .req(d_req), .addr(d_addr),
        .we(d_we), .size(), .be(d_be), .ack(q.mack[0]), .ack_rdata(MEM_RDATA)
    );
    ahb_req_port u_sc (
        .clk(CLK_SYS), .rst(RST), .htrans(SC_HTRANS), .haddr(SC_HADDR),
        .hwrite(SC_HWRITE), .hsize(SC_HSIZE), .hreadyout(SC_HREADYOUT),
        .hrdata(SC_HRDATA), .hresp(SC_HRESP), .req(s_req), .addr(s_addr),
        .we(s_we), .size(s_size), .be(s_be),
        .ack(q.st == E_DONE && !q.own_x), .ack_rdata(q.res)
    );
    ahb_req_port u_xm (
        .clk(CLK_SYS), .rst(RST), .htrans(XM_HGRANT ? XM_HTRANS : HTRANS_IDLE),
        .haddr(XM_HADDR), .hwrite(XM_HWRITE), .hsize(XM_HSIZE),
        .hreadyout(XM_HREADY), .hrdata(XM_HRDATA), .hresp(XM_HRESP),
        .req(x_req), .addr(x_addr), .we(x_we), .size(x_size), .be(x_be),
        .ack(q.st == E_DONE && q.own_x), .ack_rdata(q.res)
    );
    usec_tick #(.CYC(CYC_US)) u_tick (
        .clk(CLK_SYS), .rst(RST), .clear(q.st != E_STALL), .tick(tick)
    );

    // memory arbiter: data first, then fetch, then system alias
    assign a_req = (q.st == E_MEM) && !q.mack[2];
    assign g_d   = d_req && !q.mack[0];
    assign g_i   = i_req && !q.mack[1] && !g_d;
    assign g_a   = a_req && !g_d && !g_i;
    assign i_mem = PATCH_REMAP ? PATCH_ADDR : i_addr;
    assign sub_we = q.bb ? q.wb : q.we;

    // memory bus, answer comes one cycle after chip select
    assign MEM_CS    = g_d || g_i || g_a;
    assign MEM_WE    = g_d ? d_we : (g_a && sub_we);
    assign MEM_BE    = g_d ? d_be : (g_i ? BE_WORD : q.be);
    assign MEM_ADDR  = g_d ? d_addr : (g_i ? i_mem : q.addr - MEM_BASE);
    assign MEM_WDATA = g_d ? DA_HWDATA : q.wdata;

    // system bus master: address phase then data phase
    assign SB_HADDR  = q.addr;
    assign SB_HTRANS = (q.st == E_SADR) ? HTRANS_NONSEQ : HTRANS_IDLE;
    assign SB_HWRITE = sub_we;
    assign SB_HSIZE  = q.size;
    assign SB_HWDATA = q.wdata;

    // one transfer outstanding per master keeps the grant simple
    assign XM_HGRANT = XM_HBUSREQ && XM_HREADY;

    // debug pin sharing; a disabled port sees an idle link
    assign dp_live = q.dbg_en && !BSCAN_SEL;
    assign DP_CLK  = dp_live ? PIN_TCK : 1'b0;
    assign DP_TMS  = dp_live ? PIN_TMS_I : 1'b1;
    assign DP_TDI  = dp_live ? PIN_TDI : 1'b1;
    assign BS_TCK  = BSCAN_SEL ? PIN_TCK : 1'b0;
    assign BS_TMS  = BSCAN_SEL ? PIN_TMS_I : 1'b1;
    assign BS_TDI  = BSCAN_SEL ? PIN_TDI : 1'b1;

    // engine, memory answer tracking, debug and trace next state
    always_comb begin
        d        = q;
        take_x   = x_req && (!s_req || !q.last_x);
        a        = take_x ? x_addr : s_addr;
        off      = a - BB_ALIAS;
        fin      = 1'b0;
        fin_data = SB_HRDATA;
        d.mack   = {g_a, g_i, g_d};
        unique case (q.st)
            E_IDLE: begin
                if (s_req || x_req) begin
                    // round robin between the core and the extra master
                    d.own_x  = take_x;
                    d.last_x = take_x;
                    d.we     = take_x ? x_we : s_we;
                    d.size   = take_x ? x_size : s_size;
                    d.be     = take_x ? x_be : s_be;
                    d.wdata  = take_x ? XM_HWDATA : SC_HWDATA;
                    d.addr   = a;
                    d.bb     = 1'b0;
                    d.wb     = 1'b0;
                    if (a == STALL_ADDR) begin
                        if (d.we) begin
                            if (d.be[0]) begin
                                d.stall = d.wdata[STALL_W-1:0];
                            end
                            d.cnt = '0;
                            d.st  = E_STALL;
                        end else begin
                            d.res = {27'h0, q.stall};
                            d.st  = E_DONE;
                        end
                    end else if (off < BB_SPAN) begin
                        // alias word maps to one bit of a target word
                        d.bb     = 1'b1;
                        d.bit_no = off[6:2];
                        d.addr   = BB_TARGET + {5'h0, off[31:7], 2'h0};
                        d.size   = HSIZE_WORD;
                        d.be     = BE_WORD;
                        d.st     = route(d.addr);
                    end else begin
                        d.st = route(a);
                    end
                end
            end
            E_MEM: begin
                if (q.mack[2]) begin
                    fin      = 1'b1;
                    fin_data = MEM_RDATA;
                end
            end
            E_SADR: begin
                if (SB_HREADY) begin
                    d.st = E_SDAT;
                end
            end
            E_SDAT: begin
                fin = SB_HREADY;
            end
            E_STALL: begin
                // ready is held low at the core until n+1 ticks pass
                if (tick) begin
                    if (q.cnt == q.stall) begin
                        d.st = E_DONE;
                    end else begin
                        d.cnt = q.cnt + 5'h1;
                    end
                end
            end
            E_DONE: d.st = E_IDLE;
            default: d.st = E_IDLE;
        endcase
        // word access finished: write back a bit-band word or answer
        if (fin) begin
            if (q.bb && !q.wb && q.we) begin
                d.wb                = 1'b1;
                d.wdata             = fin_data;
                d.wdata[q.bit_no]   = q.wdata[0];
                d.st                = route(q.addr);
            end else begin
                d.res = q.bb ? {31'h0, fin_data[q.bit_no]} : fin_data;
                d.st  = E_DONE;
            end
        end
        // debug enable follows firmware; reset keeps it off
        d.dbg_en = DEBUG_ENABLE;
        d.tdo_o  = BSCAN_SEL ? BS_TDO : DP_TDO;
        d.tdo_oe = BSCAN_SEL || (dp_live && !DP_MODE_SWD);
        d.swd_o  = DP_SWDO;
        d.swd_oe = dp_live && DP_MODE_SWD && DP_SWDOEN;
        // a new hit wins over a resume in the same cycle
        d.halt = (q.halt && !DBG_RESUME) || (BP_HIT && HALT_ON_HIT && q.dbg_en);
        d.mon  = BP_HIT && !(HALT_ON_HIT && q.dbg_en);
        // trace merge: no back-pressure, so a colliding software write is dropped
        d.trc_valid = ETM_VALID || DWT_VALID || ITM_VALID;
        d.trc_data  = ETM_VALID ? ETM_DATA : (DWT_VALID ? DWT_DATA : ITM_DATA);
        d.trc_lost  = (ETM_VALID && (DWT_VALID || ITM_VALID)) ||
                      (DWT_VALID && ITM_VALID);
        if (RST) begin
            d       = '0;
            d.stall = STALL_RST;
        end
    end

    // trace runs on the same undivided clock as everything else
    always_ff @(posedge CLK_SYS) begin
        q <= d;
    end

    // registered pin and status outputs
    assign PIN_TDO_O   = q.tdo_o;
    assign PIN_TDO_OE  = q.tdo_oe;
    assign PIN_TMS_O   = q.swd_o;
    assign PIN_TMS_OE  = q.swd_oe;
    assign CORE_HALT   = q.halt;
    assign MON_EXC     = q.mon;
    assign TRACE_VALID = q.trc_valid;
    assign TRACE_DATA  = q.trc_data;
    assign TRACE_LOST  = q.trc_lost;
endmodule

// ### sim/wrap_chk.sv
// port-level assertions for the core bus wrapper
`timescale 1ns/1ps
module wrap_chk
    import wrap_pkg::*;
(
    // clock and reset
    input wire logic        CLK_SYS, RST,
    // data and system ports
    input wire logic [1:0]  DA_HTRANS, SC_HTRANS,
    input wire logic [31:0] DA_HADDR, SC_HADDR,
    input wire logic        DA_HREADYOUT, SC_HWRITE, SC_HREADYOUT, XM_HBUSREQ, MEM_CS,
    // debug and break
    input wire logic        DEBUG_ENABLE, BSCAN_SEL, PIN_TCK, DP_CLK, DP_TMS, BS_TCK,
    input wire logic        BP_HIT, HALT_ON_HIT, CORE_HALT, MON_EXC,
    // trace
    input wire logic        ETM_VALID, ITM_VALID, TRACE_VALID, TRACE_LOST,
    input wire logic [7:0]  ETM_DATA, TRACE_DATA
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // enable is registered, so both samples must agree before judging the pins
    debug_off_a: assert property (!BSCAN_SEL && !DEBUG_ENABLE && !$past(DEBUG_ENABLE)
        |-> !DP_CLK && DP_TMS) else $error("debug port not idle while disabled");
    debug_on_a: assert property (!BSCAN_SEL && DEBUG_ENABLE && $past(DEBUG_ENABLE)
        |-> DP_CLK == PIN_TCK) else $error("debug clock not passed through");
    bscan_path_a: assert property (BSCAN_SEL |-> BS_TCK == PIN_TCK)
        else $error("scan clock not passed through");
    halt_hit_a: assert property (BP_HIT && HALT_ON_HIT && DEBUG_ENABLE
        && $past(DEBUG_ENABLE) |=> CORE_HALT) else $error("hit did not halt");
    mon_exc_a: assert property (BP_HIT && !HALT_ON_HIT |=> MON_EXC)
        else $error("hit did not raise monitor");
    trace_fwd_a: assert property (ETM_VALID
        |=> TRACE_VALID && TRACE_DATA == $past(ETM_DATA))
        else $error("instruction trace byte lost");
    trace_lost_a: assert property (ETM_VALID && ITM_VALID |=> TRACE_LOST)
        else $error("collision not flagged");
    da_mem_a: assert property (DA_HTRANS[1] && DA_HREADYOUT
        && DA_HADDR[31:19] == 13'h0400
        |=> MEM_CS && !DA_HREADYOUT ##1 !DA_HREADYOUT ##1 DA_HREADYOUT)
        else $error("data port memory timing wrong");
    stall_rd_a: assert property (SC_HTRANS[1] && SC_HREADYOUT && !SC_HWRITE
        && !XM_HBUSREQ && SC_HADDR == STALL_ADDR |=> !SC_HREADYOUT [*2] ##1 SC_HREADYOUT)
        else $error("stall read delayed");
    stall_wr_a: assert property (SC_HTRANS[1] && SC_HREADYOUT && SC_HWRITE
        && SC_HADDR == STALL_ADDR |=> !SC_HREADYOUT [*4]) else $error("stall write not held");
endmodule

bind core_bus_debug_stall_wrapper wrap_chk u_chk (.*);

// ### sim/mem_partner.sv
// behavioural on-chip memory and slow system bus slave
`timescale 1ns/1ps
module mem_partner (
    // clock
    input  wire logic        CLK_SYS,
    // memory bus
    input  wire logic        MEM_CS,
    input  wire logic        MEM_WE,
    input  wire logic [3:0]  MEM_BE,
    input  wire logic [31:0] MEM_ADDR,
    input  wire logic [31:0] MEM_WDATA,
    output logic      [31:0] MEM_RDATA,
    // system bus slave
    output logic             SB_HREADY,
    output logic      [31:0] SB_HRDATA
);
    logic [31:0] mem_q [0:1023];
    initial begin
        SB_HREADY = 1'b0;
        SB_HRDATA = 32'h0;
        MEM_RDATA = 32'h0;
    end
    // read data valid only the cycle after select, otherwise it flips
    always @(posedge CLK_SYS) begin
        SB_HREADY <= ~SB_HREADY;   // one wait state per phase
        SB_HRDATA <= ~SB_HRDATA;
        MEM_RDATA <= ~MEM_RDATA;
        if (MEM_CS && MEM_WE) begin
            for (int i = 0; i < 4; i++) begin
                if (MEM_BE[i]) mem_q[MEM_ADDR[11:2]][8*i+:8] <= MEM_WDATA[8*i+:8];
            end
        end else if (MEM_CS) begin
            MEM_RDATA <= mem_q[MEM_ADDR[11:2]];
        end
    end
endmodule

// ### sim/core_bus_debug_stall_wrapper_bench.sv
// self-checking bench for the core bus wrapper
`timescale 1ns/1ps
module core_bus_debug_stall_wrapper_bench;
    import wrap_pkg::*;
    localparam int CYC = 2;   // short microsecond keeps stall runs brief
    logic CLK_SYS = 1'b0;
    logic RST, DA_HWRITE, SC_HWRITE, XM_HBUSREQ, XM_HWRITE, SB_HREADY, PATCH_REMAP, DEBUG_ENABLE;
    logic BSCAN_SEL, PIN_TCK, PIN_TMS_I, PIN_TDI, DP_SWDO, DP_SWDOEN, DP_TDO, DP_MODE_SWD, BS_TDO;
    logic BP_HIT, HALT_ON_HIT, DBG_RESUME, ITM_VALID, DWT_VALID, ETM_VALID;
    logic [1:0] IF_HTRANS, DA_HTRANS, SC_HTRANS, XM_HTRANS, SB_HTRANS;
    logic [2:0] DA_HSIZE, SC_HSIZE, XM_HSIZE, SB_HSIZE;
    logic [31:0] IF_HADDR, DA_HADDR, DA_HWDATA, SC_HADDR, SC_HWDATA, XM_HADDR, XM_HWDATA;
    logic [31:0] MEM_RDATA, SB_HRDATA, PATCH_ADDR, IF_HRDATA, DA_HRDATA, SC_HRDATA, XM_HRDATA;
    logic [31:0] MEM_ADDR, MEM_WDATA, SB_HADDR, SB_HWDATA;
    logic [7:0] ITM_DATA, DWT_DATA, ETM_DATA, TRACE_DATA;
    logic [3:0] MEM_BE;
    logic IF_HREADYOUT, IF_HRESP, DA_HREADYOUT, DA_HRESP, SC_HREADYOUT, SC_HRESP, XM_HGRANT;
    logic XM_HREADY, XM_HRESP, MEM_CS, MEM_WE, SB_HWRITE, PIN_TMS_O, PIN_TMS_OE, PIN_TDO_O;
    logic PIN_TDO_OE, DP_CLK, DP_TMS, DP_TDI, BS_TCK, BS_TMS, BS_TDI, CORE_HALT, MON_EXC;
    logic TRACE_VALID, TRACE_LOST;
    int errors = 0;
    int checks_done = 0;

    core_bus_debug_stall_wrapper #(.CYC_US(CYC)) i_dut (.*);
    mem_partner i_mem (.*);

    // free-running system clock
    always #25 CLK_SYS = ~CLK_SYS;

    task automatic cyc(input int k);
        repeat (k) @(posedge CLK_SYS);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one transfer on system (sc=1) or data port; n counts wait cycles
    task automatic acc(input bit sc, input logic [31:0] a, input bit w, input logic [31:0] d,
                       output logic [31:0] r, output int n);
        @(posedge CLK_SYS);
        if (sc) {SC_HTRANS, SC_HADDR, SC_HWRITE} <= {2'h2, a, w};
        else {DA_HTRANS, DA_HADDR, DA_HWRITE} <= {2'h2, a, w};
        @(posedge CLK_SYS);
        {SC_HTRANS, DA_HTRANS, SC_HWDATA, DA_HWDATA} <= {4'h0, d, d};
        n = 0;
        #1;
        while ((sc ? SC_HREADYOUT : DA_HREADYOUT) !== 1'b1 && n < 5000) begin
            n++;
            @(posedge CLK_SYS);
            #1;
        end
        r = sc ? SC_HRDATA : DA_HRDATA;
    endtask

    task automatic t_stall();
        logic [31:0] r;
        int n;
        acc(1, STALL_ADDR, 0, 0, r, n);
        chk(r, 32'h0);
        for (int k = 0; k < 2; k++) begin
            acc(1, STALL_ADDR, 1, k ? 32'hffff_ffff : 32'hffff_ffe0, r, n);
            chk(32'(n), 32'((k * 31 + 1) * CYC + 2));
            acc(1, STALL_ADDR, 0, 0, r, n);
            chk(r, k ? 32'h1f : 32'h0);
            chk(32'(n), 32'h2);
        end
        $display("t_stall done");
    endtask

    // word 0 only: alias offsets below 128 all map to bits of word 0
    task automatic t_mem();
        logic [31:0] r;
        int n;
        acc(0, 32'h2000_0000, 1, 32'h0000_a5a0, r, n);
        acc(0, 32'h2000_0000, 0, 0, r, n);
        chk(r, 32'h0000_a5a0);
        acc(1, 32'h2200_0000, 1, 32'h1, r, n);
        acc(1, 32'h2200_0014, 0, 0, r, n);
        chk(r, 32'h1);
        acc(0, 32'h2000_0000, 0, 0, r, n);
        chk(r, 32'h0000_a5a1);
        cyc(1);
        {IF_HTRANS, IF_HADDR, PATCH_REMAP} <= {2'h2, 32'h4, 1'b1};
        cyc(1);
        IF_HTRANS <= 2'h0;
        cyc(2);
        #1 chk(IF_HRDATA, 32'h0000_a5a1);
        $display("t_mem done");
    endtask

    task automatic t_dbg();
        cyc(1);
        PIN_TCK <= 1'b1;
        cyc(1);
        #1 chk(DP_CLK, 32'h0);
        cyc(1);
        DEBUG_ENABLE <= 1'b1;
        cyc(3);
        #1 chk(DP_CLK, 32'h1);
        cyc(1);
        BSCAN_SEL <= 1'b1;
        cyc(2);
        #1 chk(BS_TCK, 32'h1);
        chk(PIN_TDO_OE, 32'h1);
        cyc(1);
        {BSCAN_SEL, BP_HIT, HALT_ON_HIT} <= 3'b011;
        cyc(1);
        BP_HIT <= 1'b0;
        #1 chk(CORE_HALT, 32'h1);
        cyc(1);
        DBG_RESUME <= 1'b1;
        cyc(1);
        {DBG_RESUME, BP_HIT, HALT_ON_HIT} <= 3'b010;
        cyc(1);
        {BP_HIT, ETM_VALID, ITM_VALID, ETM_DATA} <= {3'b011, 8'h3c};
        #1 chk(MON_EXC, 32'h1);
        chk(CORE_HALT, 32'h0);
        cyc(1);
        {ETM_VALID, ITM_VALID} <= 2'b00;
        #1 chk(TRACE_DATA, 32'h3c);
        chk(TRACE_LOST, 32'h1);
        $display("t_dbg done");
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog sized far above the expected run of about 150 cycles
    initial begin
        cyc(20000);
        errors++;
        summarize();
    end

    initial begin
        {IF_HTRANS, DA_HTRANS, SC_HTRANS, XM_HTRANS, IF_HADDR, DA_HADDR, DA_HWDATA} = '0;
        {SC_HADDR, SC_HWDATA, XM_HADDR, XM_HWDATA, PATCH_ADDR, ITM_DATA, DWT_DATA, ETM_DATA} = '0;
        {DA_HWRITE, SC_HWRITE, XM_HBUSREQ, XM_HWRITE, PATCH_REMAP, DEBUG_ENABLE, BSCAN_SEL} = '0;
        {PIN_TCK, PIN_TMS_I, PIN_TDI, DP_SWDO, DP_SWDOEN, DP_TDO, DP_MODE_SWD, BS_TDO} = '0;
        {BP_HIT, HALT_ON_HIT, DBG_RESUME, ITM_VALID, DWT_VALID, ETM_VALID} = '0;
        {DA_HSIZE, SC_HSIZE, XM_HSIZE} = {3{HSIZE_WORD}};
        RST = 1'b1;
        cyc(16);
        RST <= 1'b0;
        t_stall();
        t_mem();
        t_dbg();
        summarize();
    end
endmodule
